// ---- logic/ckc_pkg.sv ----
// constants shared by the oscillator trim and crystal control block
package ckc_pkg;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int BYTE_SHIFT = 2;
    // register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FREQ_TRIM = 6'h11;
    localparam logic [IDX_W-1:0] IDX_TEMP_TRIM = 6'h12;
    localparam logic [IDX_W-1:0] IDX_SLOW_CTRL = 6'h18;
    localparam logic [IDX_W-1:0] IDX_XTAL_CTRL = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h1d;
    // field layout
    localparam int FREQ_TRIM_W = 6;
    localparam int TEMP_TRIM_W = 4;
    localparam int LOCK_BIT = 7;
    localparam int SLOW_KEEP_BIT = 1;
    localparam int XTAL_EN_BIT = 0;
    localparam int XTAL_KEEP_BIT = 1;
    localparam int XTAL_SEL_BIT = 2;
    localparam int CRYSTAL_STARTUP_COUNT_LSB = 4;
    localparam int CRYSTAL_STARTUP_COUNT_W = 2;
    localparam int STAT_XTAL_BIT = 6;
    localparam int STAT_SLOW_BIT = 5;
    // reset values
    localparam logic [FREQ_TRIM_W-1:0] FREQ_TRIM_RST = 6'h00;
    localparam logic [TEMP_TRIM_W-1:0] TEMP_TRIM_RST = 4'h0;
    localparam logic [CRYSTAL_STARTUP_COUNT_W-1:0] CRYSTAL_STARTUP_COUNT_RST = 2'h0;
    localparam logic BIT_RST = 1'b0;
    // start-up codes and their lengths in crystal cycles
    localparam logic [CRYSTAL_STARTUP_COUNT_W-1:0] CRYSTAL_STARTUP_COUNT_1K = 2'h0;
    localparam logic [CRYSTAL_STARTUP_COUNT_W-1:0] CRYSTAL_STARTUP_COUNT_16K = 2'h1;
    localparam logic [CRYSTAL_STARTUP_COUNT_W-1:0] CRYSTAL_STARTUP_COUNT_32K = 2'h2;
    localparam logic [CRYSTAL_STARTUP_COUNT_W-1:0] CRYSTAL_STARTUP_COUNT_64K = 2'h3;
    localparam int STARTUP_1K = 1024;
    localparam int STARTUP_16K = 16384;
    localparam int STARTUP_32K = 32768;
    localparam int STARTUP_64K = 65536;
    localparam int STARTUP_CNT_W = 17;
    // gate delays in oscillator cycles
    localparam int GATE_CNT_W = 3;
    localparam logic [GATE_CNT_W-1:0] SLOW_GATE_TICKS = 3'h4;
    localparam logic [GATE_CNT_W-1:0] XTAL_GATE_TICKS = 3'h2;
endpackage

// ---- logic/ckc_tick_counter.sv ----
// counts oscillator ticks up to a target and then holds done
`timescale 1ns/100ps
module ckc_tick_counter #(
    parameter int CNT_W = 3
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic tick,
    input wire logic [CNT_W-1:0] target,
    output logic done
);
    initial begin
        if (CNT_W < 1) begin
            $error("ckc_tick_counter: CNT_W must be at least 1");
        end
    end

    logic [CNT_W-1:0] count_reg;
    logic done_reg;
    wire logic atEnd = (count_reg == target - {{(CNT_W-1){1'b0}}, 1'b1});
    wire logic step = tick && !done_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else if (clear) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else if (step) begin
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            done_reg <= atEnd;
        end
    end

    assign done = done_reg;
endmodule // ckc_tick_counter

// ---- logic/ckc_osc_ctrl.sv ----
// oscillator trim, slow rc and crystal oscillator control with apb registers
`timescale 1ns/100ps
module ckc_osc_ctrl
    import ckc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int STARTUP_1K_P = ckc_pkg::STARTUP_1K,
    parameter int STARTUP_16K_P = ckc_pkg::STARTUP_16K,
    parameter int STARTUP_32K_P = ckc_pkg::STARTUP_32K,
    parameter int STARTUP_64K_P = ckc_pkg::STARTUP_64K
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [ckc_pkg::DATA_W-1:0] pwdata,
    output logic [ckc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfgUnlock,
    input wire logic freqSelectFuse,
    input wire logic lockFuseBit,
    input wire logic [ckc_pkg::FREQ_TRIM_W-1:0] factFreqTrimLow,
    input wire logic [ckc_pkg::FREQ_TRIM_W-1:0] factFreqTrimHigh,
    input wire logic [ckc_pkg::TEMP_TRIM_W-1:0] factTempTrimLow,
    input wire logic [ckc_pkg::TEMP_TRIM_W-1:0] factTempTrimHigh,
    output logic [ckc_pkg::FREQ_TRIM_W-1:0] freqTrim,
    output logic [ckc_pkg::TEMP_TRIM_W-1:0] tempSlopeTrim,
    input wire logic slowRcReq,
    input wire logic slowRcTick,
    output logic slowRcPowerOn,
    output logic slowRcClkGate,
    output logic slowRcStable,
    input wire logic crystalReq,
    input wire logic crystalTick,
    output logic crystalPowerOn,
    output logic crystalPinOverride,
    output logic crystalExtClkMode,
    output logic crystalClkGate,
    output logic crystalStable
);
    import ckc_pkg::*;

    initial begin
        if (ADDR_W < IDX_W + BYTE_SHIFT) begin
            $error("ckc_osc_ctrl: ADDR_W too small for the register map");
        end
        if (STARTUP_64K_P >= (1 << STARTUP_CNT_W) || STARTUP_1K_P < 1) begin
            $error("ckc_osc_ctrl: start-up counts do not fit the counter");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic loadPending_reg;
    logic lock_reg;
    logic [FREQ_TRIM_W-1:0] freqTrim_reg;
    logic [TEMP_TRIM_W-1:0] tempTrim_reg;
    logic slowKeep_reg;
    logic xEnable_reg;
    logic xKeep_reg;
    logic xSel_reg;
    logic [CRYSTAL_STARTUP_COUNT_W-1:0] xCsut_reg;
    logic [DATA_W-1:0] prdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire logic [IDX_W-1:0] regIdx = paddr[IDX_W+BYTE_SHIFT-1:BYTE_SHIFT];
    wire logic addrAligned = (paddr[BYTE_SHIFT-1:0] == '0);
    wire logic upperZero = (paddr >> (IDX_W + BYTE_SHIFT)) == '0;
    wire logic hitFreq = (regIdx == IDX_FREQ_TRIM);
    wire logic hitTemp = (regIdx == IDX_TEMP_TRIM);
    wire logic hitSlow = (regIdx == IDX_SLOW_CTRL);
    wire logic hitXtal = (regIdx == IDX_XTAL_CTRL);
    wire logic hitStat = (regIdx == IDX_STATUS);
    wire logic mapped = addrAligned && upperZero && (hitFreq || hitTemp || hitSlow || hitXtal
                                                     || hitStat);
    wire logic setupPhase = psel && !penable;
    wire logic accessPhase = psel && penable;
    wire logic apbWrite = accessPhase && pwrite && mapped;
    wire logic wrOk = apbWrite && cfgUnlock && !loadPending_reg;
    wire logic trimWrOk = wrOk && !lock_reg;
    wire logic wrFreq = trimWrOk && hitFreq;
    wire logic wrTemp = trimWrOk && hitTemp;
    wire logic wrSlow = wrOk && hitSlow;
    wire logic wrXtal = wrOk && hitXtal;
    wire logic xCfgFrozen = xEnable_reg || crystalStable;
    wire logic wrXtalCfg = wrXtal && !xCfgFrozen;

    assign pready = 1'b1;
    assign pslverr = accessPhase && !mapped;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    wire logic [DATA_W-1:0] rdFreq = {{(DATA_W-FREQ_TRIM_W){1'b0}}, freqTrim_reg};
    wire logic [DATA_W-1:0] rdTemp = (DATA_W'(lock_reg) << LOCK_BIT)
                                     | {{(DATA_W-TEMP_TRIM_W){1'b0}}, tempTrim_reg};
    wire logic [DATA_W-1:0] rdSlow = DATA_W'(slowKeep_reg) << SLOW_KEEP_BIT;
    wire logic [DATA_W-1:0] rdXtal = (DATA_W'(xCsut_reg) << CRYSTAL_STARTUP_COUNT_LSB)
                                     | (DATA_W'(xSel_reg) << XTAL_SEL_BIT)
                                     | (DATA_W'(xKeep_reg) << XTAL_KEEP_BIT)
                                     | (DATA_W'(xEnable_reg) << XTAL_EN_BIT);
    wire logic [DATA_W-1:0] rdStat = (DATA_W'(crystalStable) << STAT_XTAL_BIT)
                                     | (DATA_W'(slowRcStable) << STAT_SLOW_BIT);
    wire logic [DATA_W-1:0] rdMux = !mapped ? '0 : hitFreq ? rdFreq : hitTemp ? rdTemp
                                    : hitSlow ? rdSlow : hitXtal ? rdXtal : rdStat;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= '0;
        end else if (setupPhase && !pwrite) begin
            prdata_reg <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fast oscillator trim and lock, loaded from fuses after reset release

    wire logic [FREQ_TRIM_W-1:0] fuseFreq = freqSelectFuse ? factFreqTrimHigh : factFreqTrimLow;
    wire logic [TEMP_TRIM_W-1:0] fuseTemp = freqSelectFuse ? factTempTrimHigh : factTempTrimLow;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            loadPending_reg <= 1'b1;
            lock_reg <= BIT_RST;
            freqTrim_reg <= FREQ_TRIM_RST;
            tempTrim_reg <= TEMP_TRIM_RST;
        end else if (loadPending_reg) begin
            loadPending_reg <= 1'b0;
            lock_reg <= lockFuseBit;
            freqTrim_reg <= fuseFreq;
            tempTrim_reg <= fuseTemp;
        end else begin
            if (wrFreq) begin
                freqTrim_reg <= pwdata[FREQ_TRIM_W-1:0];
            end
            if (wrTemp) begin
                tempTrim_reg <= pwdata[TEMP_TRIM_W-1:0];
            end
        end
    end

    assign freqTrim = freqTrim_reg;
    assign tempSlopeTrim = tempTrim_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            slowKeep_reg <= BIT_RST;
            xEnable_reg <= BIT_RST;
            xKeep_reg <= BIT_RST;
            xSel_reg <= BIT_RST;
            xCsut_reg <= CRYSTAL_STARTUP_COUNT_RST;
        end else begin
            if (wrSlow) begin
                slowKeep_reg <= pwdata[SLOW_KEEP_BIT];
            end
            if (wrXtal) begin
                xEnable_reg <= pwdata[XTAL_EN_BIT];
                xKeep_reg <= pwdata[XTAL_KEEP_BIT];
            end
            if (wrXtalCfg) begin
                xSel_reg <= pwdata[XTAL_SEL_BIT];
                xCsut_reg <= pwdata[CRYSTAL_STARTUP_COUNT_LSB+CRYSTAL_STARTUP_COUNT_W-1:CRYSTAL_STARTUP_COUNT_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slow rc oscillator

    logic slowGateDone;

    assign slowRcPowerOn = slowKeep_reg || slowRcReq;

    ckc_tick_counter #(.CNT_W(GATE_CNT_W)) slowGate (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clear(!slowRcReq),
        .tick(slowRcTick),
        .target(SLOW_GATE_TICKS),
        .done(slowGateDone)
    );

    assign slowRcClkGate = slowGateDone && slowRcReq;
    assign slowRcStable = slowRcClkGate;

    ////////////////////////////////////////////////////////////////////////////////
    // crystal oscillator

    logic startupDone;
    logic xGateDone;
    logic [STARTUP_CNT_W-1:0] startupTarget;

    always_comb begin
        unique case (xCsut_reg)
            CRYSTAL_STARTUP_COUNT_1K: startupTarget = STARTUP_CNT_W'(STARTUP_1K_P);
            CRYSTAL_STARTUP_COUNT_16K: startupTarget = STARTUP_CNT_W'(STARTUP_16K_P);
            CRYSTAL_STARTUP_COUNT_32K: startupTarget = STARTUP_CNT_W'(STARTUP_32K_P);
            CRYSTAL_STARTUP_COUNT_64K: startupTarget = STARTUP_CNT_W'(STARTUP_64K_P);
        endcase
    end

    assign crystalPowerOn = xEnable_reg && (xKeep_reg || crystalReq);
    assign crystalPinOverride = xEnable_reg;
    assign crystalExtClkMode = xSel_reg;

    ckc_tick_counter #(.CNT_W(STARTUP_CNT_W)) xStartup (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clear(!crystalPowerOn || xSel_reg),
        .tick(crystalTick),
        .target(startupTarget),
        .done(startupDone)
    );

    wire logic startupOk = crystalPowerOn && (xSel_reg || startupDone);

    ckc_tick_counter #(.CNT_W(GATE_CNT_W)) xGate (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clear(!(crystalReq && startupOk)),
        .tick(crystalTick),
        .target(XTAL_GATE_TICKS),
        .done(xGateDone)
    );

    assign crystalClkGate = xGateDone && crystalReq && startupOk;
    assign crystalStable = crystalClkGate;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence sLockedWrite;
        accessPhase && pwrite && !cfgUnlock && !loadPending_reg;
    endsequence

    sequence sTrimWriteLocked;
        accessPhase && pwrite && lock_reg && !loadPending_reg && (hitFreq || hitTemp);
    endsequence

    // ticks seen in external clock mode while requested, saturating at the gate count
    logic [GATE_CNT_W-1:0] extTicks_reg;
    wire logic extReq = crystalReq && crystalPowerOn && xSel_reg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            extTicks_reg <= '0;
        end else if (!extReq) begin
            extTicks_reg <= '0;
        end else if (crystalTick && extTicks_reg != XTAL_GATE_TICKS) begin
            extTicks_reg <= extTicks_reg + {{(GATE_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    a_trim_lock_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sTrimWriteLocked |=> $stable(freqTrim_reg) && $stable(tempTrim_reg))
        else $error("trim changed while locked");

    a_lock_fuse_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
        loadPending_reg |=> lock_reg == $past(lockFuseBit) && !loadPending_reg)
        else $error("lock not loaded from fuse");

    a_freq_fuse_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
        loadPending_reg |=> freqTrim == $past(fuseFreq) && tempSlopeTrim == $past(fuseTemp))
        else $error("trims not loaded from factory values");

    a_slow_keep_power: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(slowRcReq) && slowKeep_reg |-> slowRcPowerOn && !slowRcClkGate)
        else $error("slow oscillator power or gate wrong after request drop");

    a_slow_gate_delay: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(slowRcReq) |-> !slowRcClkGate [*4])
        else $error("slow gate opened too early");

    a_xtal_cfg_frozen: assert property (@(posedge sys_clk) disable iff (!arst_n)
        apbWrite && hitXtal && xCfgFrozen |=> $stable(xSel_reg) && $stable(xCsut_reg))
        else $error("crystal select or startup changed while frozen");

    a_unlock_needed: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sLockedWrite |=> $stable(xEnable_reg) && $stable(xKeep_reg) && $stable(slowKeep_reg)
                         && $stable(freqTrim_reg) && $stable(tempTrim_reg)
                         && $stable(xSel_reg) && $stable(xCsut_reg))
        else $error("register changed outside unlock window");

    a_xtal_startup_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(crystalPowerOn) && !xSel_reg |-> !crystalClkGate [*8])
        else $error("crystal output before startup wait");

    a_ext_clk_skip: assert property (@(posedge sys_clk) disable iff (!arst_n)
        extReq && extTicks_reg == XTAL_GATE_TICKS |-> crystalClkGate)
        else $error("external clock mode waited for startup");

    a_xtal_power: assert property (@(posedge sys_clk) disable iff (!arst_n)
        crystalPowerOn |-> xEnable_reg && (xKeep_reg || crystalReq))
        else $error("crystal powered without enable");

    a_stable_requested: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (crystalStable |-> crystalReq) and (slowRcStable |-> slowRcReq))
        else $error("stable status without request");
endmodule // ckc_osc_ctrl

// ---- test/ckc_osc_model.sv ----
// behavioural oscillator cores: tick pulses only while powered
`timescale 1ns/100ps
module ckc_osc_model #(
    parameter int SLOW_PERIOD = 3,
    parameter int XTAL_PERIOD = 4
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic slowRcPowerOn,
    input wire logic crystalPowerOn,
    output logic slowRcTick,
    output logic crystalTick
);
    int slowCnt;
    int xtalCnt;
    ////////////////////////////////////////////////////////////////////////////////
    // a core that is not powered makes no cycles at all
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            slowCnt <= 0;
            xtalCnt <= 0;
            slowRcTick <= 1'b0;
            crystalTick <= 1'b0;
        end else begin
            slowCnt <= slowRcPowerOn ? (slowCnt + 1) % SLOW_PERIOD : 0;
            xtalCnt <= crystalPowerOn ? (xtalCnt + 1) % XTAL_PERIOD : 0;
            slowRcTick <= slowRcPowerOn && slowCnt == SLOW_PERIOD - 1;
            crystalTick <= crystalPowerOn && xtalCnt == XTAL_PERIOD - 1;
        end
    end
endmodule // ckc_osc_model

// ---- test/ckc_osc_ctrl_bench.sv ----
// self-checking bench for the oscillator trim and crystal control block
`timescale 1ns/100ps
module ckc_osc_ctrl_bench;
    import ckc_pkg::*;
    localparam logic [5:0] FL = 6'h15;
    localparam logic [5:0] FH = 6'h2a;
    localparam logic [3:0] TL = 4'h5;
    localparam logic [3:0] TH = 4'ha;
    localparam int SU_STEP = 4;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, cfgUnlock;
    logic freqSelectFuse, lockFuseBit, slowRcReq, slowRcTick, slowRcPowerOn, slowRcClkGate;
    logic slowRcStable, crystalReq, crystalTick, crystalPowerOn, crystalPinOverride;
    logic crystalExtClkMode, crystalClkGate, crystalStable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] freqTrim;
    logic [3:0] tempSlopeTrim;
    int nFail = 0;
    int testsRun = 0;
    ////////////////////////////////////////////////////////////////////////////////
    ckc_osc_ctrl #(.ADDR_W(8), .STARTUP_1K_P(SU_STEP), .STARTUP_16K_P(2 * SU_STEP),
        .STARTUP_32K_P(3 * SU_STEP), .STARTUP_64K_P(4 * SU_STEP)) dut (.sys_clk(sys_clk),
        .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfgUnlock(cfgUnlock),
        .freqSelectFuse(freqSelectFuse), .lockFuseBit(lockFuseBit), .factFreqTrimLow(FL),
        .factFreqTrimHigh(FH), .factTempTrimLow(TL), .factTempTrimHigh(TH),
        .freqTrim(freqTrim), .tempSlopeTrim(tempSlopeTrim), .slowRcReq(slowRcReq),
        .slowRcTick(slowRcTick), .slowRcPowerOn(slowRcPowerOn), .slowRcClkGate(slowRcClkGate),
        .slowRcStable(slowRcStable), .crystalReq(crystalReq), .crystalTick(crystalTick),
        .crystalPowerOn(crystalPowerOn), .crystalPinOverride(crystalPinOverride),
        .crystalExtClkMode(crystalExtClkMode), .crystalClkGate(crystalClkGate),
        .crystalStable(crystalStable));
    ckc_osc_model model (.sys_clk(sys_clk), .arst_n(arst_n), .slowRcPowerOn(slowRcPowerOn),
        .crystalPowerOn(crystalPowerOn), .slowRcTick(slowRcTick), .crystalTick(crystalTick));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testDone();
        if (nFail == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, rd, err);
    endtask
    task automatic rdChk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0, rd, err);
        chk(rd, exp, msg);
    endtask
    task automatic doReset(input logic sel, input logic lock);
        freqSelectFuse <= sel;
        lockFuseBit <= lock;
        arst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic countTicks(input logic xtal, output int n);
        int i;
        n = 0;
        for (i = 0; i < 500; i++) begin
            @(negedge sys_clk);
            if ((xtal ? crystalClkGate : slowRcClkGate) === 1'b1) break;
            if ((xtal ? crystalTick : slowRcTick) === 1'b1) n++;
        end
        chk(32'(i == 500), 32'h0, "gate never opened");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testResetAndWrites();
        doReset(1'b1, 1'b0);
        rdChk(IDX_FREQ_TRIM, {26'h0, FH}, "freq trim reset");
        rdChk(IDX_TEMP_TRIM, {28'h0, TH}, "temp trim reset");
        rdChk(IDX_SLOW_CTRL, 32'h0, "slow reset");
        rdChk(IDX_XTAL_CTRL, 32'h0, "xtal reset");
        cfgUnlock <= 1'b1;
        wr(IDX_FREQ_TRIM, 32'h3c);
        wr(IDX_TEMP_TRIM, 32'h03);
        rdChk(IDX_FREQ_TRIM, 32'h3c, "freq trim write");
        chk({26'h0, freqTrim}, 32'h3c, "freq trim port");
        chk({28'h0, tempSlopeTrim}, 32'h3, "temp trim port");
        cfgUnlock <= 1'b0;
        wr(IDX_FREQ_TRIM, 32'h11);
        wr(IDX_SLOW_CTRL, 32'h02);
        rdChk(IDX_FREQ_TRIM, 32'h3c, "protected freq write");
        rdChk(IDX_SLOW_CTRL, 32'h0, "protected slow write");
        cfgUnlock <= 1'b1;
    endtask
    task automatic testLock();
        logic [31:0] rd;
        logic err;
        doReset(1'b0, 1'b1);
        rdChk(IDX_FREQ_TRIM, {26'h0, FL}, "freq trim low");
        wr(IDX_FREQ_TRIM, 32'h01);
        wr(IDX_TEMP_TRIM, 32'h0f);
        rdChk(IDX_FREQ_TRIM, {26'h0, FL}, "locked freq");
        rdChk(IDX_TEMP_TRIM, {24'h0, 4'h8, TL}, "locked temp");
        apb(1'b0, 6'h20, 32'h0, rd, err);
        chk(rd, 32'h0, "unmapped data");
        chk({31'h0, err}, 32'h1, "unmapped error");
        doReset(1'b1, 1'b0);
    endtask
    task automatic testSlow();
        int n;
        wr(IDX_SLOW_CTRL, 32'h0);
        @(negedge sys_clk);
        chk({31'h0, slowRcPowerOn}, 32'h0, "slow idle power");
        @(posedge sys_clk);
        slowRcReq <= 1'b1;
        countTicks(1'b0, n);
        chk(n, 4, "slow gate ticks");
        rdChk(IDX_STATUS, 32'h20, "slow stable");
        slowRcReq <= 1'b0;
        wr(IDX_SLOW_CTRL, 32'h02);
        @(negedge sys_clk);
        chk({31'h0, slowRcPowerOn}, 32'h1, "slow kept power");
        chk({31'h0, slowRcClkGate}, 32'h0, "slow gate closed");
        rdChk(IDX_STATUS, 32'h0, "slow kept unstable");
        slowRcReq <= 1'b1;
        countTicks(1'b0, n);
        chk(n, 4, "kept slow gate ticks");
        @(posedge sys_clk);
        slowRcReq <= 1'b0;
        @(negedge sys_clk);
        chk({31'h0, slowRcPowerOn}, 32'h1, "slow power after drop");
        chk({31'h0, slowRcClkGate}, 32'h0, "slow gate after drop");
    endtask
    task automatic testCrystal();
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(IDX_XTAL_CTRL, {26'h0, 2'(c), 4'h1});
            @(negedge sys_clk);
            chk({31'h0, crystalPinOverride}, 32'h1, "pin override");
            chk({31'h0, crystalPowerOn}, 32'h0, "unrequested power");
            @(posedge sys_clk);
            crystalReq <= 1'b1;
            countTicks(1'b1, n);
            chk(n, (c + 1) * SU_STEP + 2, "startup ticks");
            rdChk(IDX_STATUS, 32'h40, "xtal stable");
            wr(IDX_XTAL_CTRL, {26'h0, 2'(c ^ 3), 4'h5});
            rdChk(IDX_XTAL_CTRL, {26'h0, 2'(c), 4'h1}, "frozen fields");
            crystalReq <= 1'b0;
            wr(IDX_XTAL_CTRL, 32'h0);
            rdChk(IDX_STATUS, 32'h0, "xtal unstable");
            rdChk(IDX_XTAL_CTRL, {26'h0, 2'(c), 4'h0}, "fields kept");
        end
        wr(IDX_XTAL_CTRL, 32'h05);
        @(negedge sys_clk);
        chk({31'h0, crystalExtClkMode}, 32'h1, "ext clock mode");
        @(posedge sys_clk);
        crystalReq <= 1'b1;
        countTicks(1'b1, n);
        chk(n, 2, "ext clock ticks");
        @(posedge sys_clk);
        crystalReq <= 1'b0;
        wr(IDX_XTAL_CTRL, 32'h0);
        wr(IDX_XTAL_CTRL, 32'h03);
        @(negedge sys_clk);
        chk({31'h0, crystalExtClkMode}, 32'h0, "crystal mode");
        chk({31'h0, crystalPowerOn}, 32'h1, "kept power");
        rdChk(IDX_STATUS, 32'h0, "kept unrequested");
        repeat (40) @(posedge sys_clk);
        crystalReq <= 1'b1;
        countTicks(1'b1, n);
        chk(n, 2, "kept request ticks");
        @(posedge sys_clk);
        crystalReq <= 1'b0;
        cfgUnlock <= 1'b0;
        wr(IDX_XTAL_CTRL, 32'h0);
        rdChk(IDX_XTAL_CTRL, 32'h03, "protected enable");
        cfgUnlock <= 1'b1;
        wr(IDX_XTAL_CTRL, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        nFail++;
        testDone();
    end
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfgUnlock = 1'b0;
        freqSelectFuse = 1'b1;
        lockFuseBit = 1'b0;
        slowRcReq = 1'b0;
        crystalReq = 1'b0;
        testResetAndWrites();
        testLock();
        testSlow();
        testCrystal();
        testDone();
    end
endmodule // ckc_osc_ctrl_bench
